//--- hw/uef_pkg.sv
// Package for the USB endpoint interrupt-pending flag block.
// Assumes a 32-bit APB slave, one clock, offsets as word indices.
package uef_pkg;
  // Printed offsets are not all multiples of four: kept as word indices
  localparam logic [7:0]  IDX_IN_FLAGS    = 8'h02;
  localparam logic [7:0]  IDX_OUT_FLAGS   = 8'h04;
  localparam logic [7:0]  IDX_IRQ_STATUS  = 8'h10;
  localparam logic [7:0]  IDX_IRQ_ENABLE  = 8'h11;
  localparam logic [7:0]  IDX_IRQ_CLEAR   = 8'h12;
  localparam logic [7:0]  IDX_EXT_ENABLE  = 8'h13;
  localparam logic [7:0]  IN_FLAGS_RESET  = 8'h00;
  localparam logic [7:0]  OUT_FLAGS_RESET = 8'h00;
  localparam logic [3:0]  IN_FLAGS_MASK   = 4'hf;
  localparam logic [3:0]  OUT_FLAGS_MASK  = 4'he;
  localparam logic [1:0]  EVT_RESET       = 2'h0;
  localparam logic [1:0]  EVT_ENABLE_RESET = 2'h3;
  localparam int          EVT_IN_BIT      = 0;
  localparam int          EVT_OUT_BIT     = 1;

  // Byte address of a word index
  function automatic logic [9:0] uef_addr(input logic [7:0] idx);
    uef_addr = {idx, 2'h0};
  endfunction
endpackage

//--- hw/uef_flag_bank.sv
// One 4-bit pending-flag bank with clear-on-read.
// Assumes set pulses are synchronous to sys_clk.
`timescale 1ns/1ps
module uef_flag_bank (
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  input  wire logic       clk_en,
  // Flag control
  input  wire logic [3:0] set_pulse,
  input  wire logic [3:0] valid_mask,
  input  wire logic       read_clear,
  // Flag state
  output logic      [3:0] flags
);
  typedef struct packed {
    logic [3:0] flags;
  } uef_bank_t;

  uef_bank_t s_r;
  uef_bank_t s_nxt;

  always_comb begin
    s_nxt = s_r;
    // Set beats clear so an event landing on the read is not lost
    if (read_clear) begin
      s_nxt.flags = 4'h0; // RULE3
    end
    s_nxt.flags = (s_nxt.flags | set_pulse) & valid_mask;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '0; // RULE9
    end else if (clk_en) begin
      s_r <= s_nxt;
    end
  end

  assign flags = s_r.flags;

  clear_on_read_a: assert property ( // RULE3
    @(posedge sys_clk) disable iff (!rst_n)
    clk_en && read_clear && set_pulse == 4'h0
    |=> flags == 4'h0)
    else $error("Flags survived a clearing read");
  set_sticks_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    clk_en && |(set_pulse & valid_mask)
    |=> (flags & $past(set_pulse & valid_mask)) != 4'h0)
    else $error("Set pulse lost");
endmodule

//--- hw/uef_apb_port.sv
// APB slave decode: one-wait answer, error on unmapped address.
// Assumes a standard APB master with 32-bit data.
`timescale 1ns/1ps
module uef_apb_port (
  // APB request
  input  wire logic       psel,
  input  wire logic       penable,
  input  wire logic       pwrite,
  input  wire logic [9:0] paddr,
  // Decoded access
  output logic            acc_rd,
  output logic            acc_wr,
  output logic [2:0]      acc_sel,
  output logic            acc_bad
);
  logic acc;

  always_comb begin
    acc     = psel && penable;
    acc_rd  = acc && !pwrite;
    acc_wr  = acc && pwrite;
    acc_sel = 3'h0;
    acc_bad = 1'b0;
    if (paddr == uef_pkg::uef_addr(uef_pkg::IDX_IN_FLAGS)) begin
      acc_sel = 3'h1;
    end else if (paddr == uef_pkg::uef_addr(uef_pkg::IDX_OUT_FLAGS)) begin
      acc_sel = 3'h2;
    end else if (paddr == uef_pkg::uef_addr(uef_pkg::IDX_IRQ_STATUS)) begin
      acc_sel = 3'h3;
    end else if (paddr == uef_pkg::uef_addr(uef_pkg::IDX_IRQ_ENABLE)) begin
      acc_sel = 3'h4;
    end else if (paddr == uef_pkg::uef_addr(uef_pkg::IDX_IRQ_CLEAR)) begin
      acc_sel = 3'h5;
    end else if (paddr == uef_pkg::uef_addr(uef_pkg::IDX_EXT_ENABLE)) begin
      acc_sel = 3'h6;
    end else begin
      acc_bad = acc;
    end
  end
endmodule

//--- hw/uef_top.sv
// Top of the USB endpoint interrupt-pending flag block with APB access.
// Assumes set pulses from the endpoint logic, one sys_clk at 40 MHz.
`timescale 1ns/1ps
// Overview of operation
// RULE1: Flag registers are read-only; writes never change any flag.
// RULE2: Combined request is high whenever any pending flag is one.
// RULE3: Reading a flag register clears all its flags to zero; a flag set in the same cycle as the read stays set.
// RULE4: Enable bits live in separate registers, never sharing flag storage.
// RULE5: Request reaches the processor only when the extended enable bit set.
// RULE6: IN register: control endpoint bit 0, IN endpoints 1..3 bits 1..3.
// RULE7: OUT register: OUT endpoints 1..3 in bits 1..3, bit 0 unused.
// RULE8: Reading the OUT register clears each OUT flag it returns.
// RULE9: Bits 7..4 read zero, ignore writes; both registers reset to zero.
module uef_top (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic        clk_en,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [9:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Endpoint event pulses
  input  wire logic        control_ep_set,
  input  wire logic        tx_ep1_set,
  input  wire logic        tx_ep2_set,
  input  wire logic        tx_ep3_set,
  input  wire logic        rx_ep1_set,
  input  wire logic        rx_ep2_set,
  input  wire logic        rx_ep3_set,
  // Interrupt outputs
  output logic             usb_irq_req,
  output logic             irq
);
  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        ext_en;
    logic [1:0]  evt_en;
    logic [1:0]  evt_stat;
    logic        irq_req;
    logic        irq;
  } uef_state_t;

  uef_state_t s_r;
  uef_state_t s_nxt;

  logic       acc_rd;
  logic       acc_wr;
  logic [2:0] acc_sel;
  logic       acc_bad;
  logic [3:0] in_flags;
  logic [3:0] out_flags;
  logic [3:0] in_set;
  logic [3:0] out_set;
  logic       rd_in;
  logic       rd_out;
  logic [1:0] evt;
  logic [1:0] evt_clr;
  logic       first;

  uef_apb_port u_apb (
    .psel    (psel),
    .penable (penable),
    .pwrite  (pwrite),
    .paddr   (paddr),
    .acc_rd  (acc_rd),
    .acc_wr  (acc_wr),
    .acc_sel (acc_sel),
    .acc_bad (acc_bad)
  );

  // Bit order of each bank
  assign in_set  = {tx_ep3_set, tx_ep2_set, tx_ep1_set, control_ep_set}; // RULE6
  assign out_set = {rx_ep3_set, rx_ep2_set, rx_ep1_set, 1'b0}; // RULE7
  // Clear only on the access edge, once per transfer (pready is low)
  assign first   = !s_r.pready;
  assign rd_in   = acc_rd && first && acc_sel == 3'h1; // RULE3
  assign rd_out  = acc_rd && first && acc_sel == 3'h2; // RULE8

  // Flags are separate from every enable bit below
  uef_flag_bank u_in_bank ( // RULE4
    .sys_clk    (sys_clk),
    .rst_n      (rst_n),
    .clk_en     (clk_en),
    .set_pulse  (in_set),
    .valid_mask (uef_pkg::IN_FLAGS_MASK),
    .read_clear (rd_in),
    .flags      (in_flags)
  );

  uef_flag_bank u_out_bank (
    .sys_clk    (sys_clk),
    .rst_n      (rst_n),
    .clk_en     (clk_en),
    .set_pulse  (out_set),
    .valid_mask (uef_pkg::OUT_FLAGS_MASK),
    .read_clear (rd_out),
    .flags      (out_flags)
  );

  always_comb begin
    s_nxt   = s_r;
    evt     = 2'h0;
    evt_clr = 2'h0;
    evt[uef_pkg::EVT_IN_BIT]  = |in_set;
    evt[uef_pkg::EVT_OUT_BIT] = |(out_set & uef_pkg::OUT_FLAGS_MASK);
    // One wait state: pready rises on the access cycle, drops after it
    s_nxt.pready  = acc_rd || acc_wr ? first : 1'b0;
    s_nxt.pslverr = acc_bad && first;
    if (acc_rd && first) begin
      if (acc_sel == 3'h1) begin
        s_nxt.prdata = {28'h0, in_flags}; // RULE9
      end else if (acc_sel == 3'h2) begin
        s_nxt.prdata = {28'h0, out_flags}; // RULE9
      end else if (acc_sel == 3'h3) begin
        s_nxt.prdata = {30'h0, s_r.evt_stat};
      end else if (acc_sel == 3'h4) begin
        s_nxt.prdata = {30'h0, s_r.evt_en};
      end else if (acc_sel == 3'h6) begin
        s_nxt.prdata = {31'h0, s_r.ext_en};
      end else begin
        s_nxt.prdata = 32'h0;
      end
    end
    // Flag registers take no write path at all
    if (acc_wr && first) begin // RULE1
      if (acc_sel == 3'h4) begin
        s_nxt.evt_en = pwdata[1:0];
      end else if (acc_sel == 3'h5) begin
        evt_clr = pwdata[1:0];
      end else if (acc_sel == 3'h6) begin
        s_nxt.ext_en = pwdata[0];
      end
    end
    // Set wins over clear
    s_nxt.evt_stat = (s_r.evt_stat & ~evt_clr) | evt;
    s_nxt.irq_req  = s_r.ext_en && (|in_flags || |out_flags); // RULE2 RULE5
    s_nxt.irq      = |(s_nxt.evt_stat & s_r.evt_en);
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r         <= '0;
      s_r.evt_en  <= uef_pkg::EVT_ENABLE_RESET;
    end else if (clk_en) begin
      s_r <= s_nxt;
    end
  end

  assign prdata      = s_r.prdata;
  assign pready      = s_r.pready;
  assign pslverr     = s_r.pslverr;
  assign usb_irq_req = s_r.irq_req;
  assign irq         = s_r.irq;

  // Combined request
  irq_follows_flags_a: assert property ( // RULE2
    @(posedge sys_clk) disable iff (!rst_n)
    clk_en && s_r.ext_en && (|in_flags || |out_flags)
    |=> usb_irq_req)
    else $error("Request missing while a flag is set");
  irq_gated_a: assert property ( // RULE5
    @(posedge sys_clk) disable iff (!rst_n)
    clk_en && !s_r.ext_en
    |=> !usb_irq_req)
    else $error("Request delivered while disabled");
  no_flag_quiet_a: assert property ( // RULE2
    @(posedge sys_clk) disable iff (!rst_n)
    clk_en && !(|in_flags || |out_flags)
    |=> !usb_irq_req)
    else $error("Request raised with no flag set");
  ext_en_write_a: assert property ( // RULE5
    @(posedge sys_clk) disable iff (!rst_n)
    clk_en && acc_wr && first && acc_sel == 3'h6
    |=> s_r.ext_en == $past(pwdata[0]))
    else $error("Extended enable write lost");

  // Flag banks
  write_ignored_a: assert property ( // RULE1
    @(posedge sys_clk) disable iff (!rst_n)
    clk_en && acc_wr && (acc_sel == 3'h1) && in_set == 4'h0
    |=> in_flags == $past(in_flags))
    else $error("Write changed IN flags");
  out_write_ignored_a: assert property ( // RULE1
    @(posedge sys_clk) disable iff (!rst_n)
    clk_en && acc_wr && (acc_sel == 3'h2) && out_set == 4'h0
    |=> out_flags == $past(out_flags))
    else $error("Write changed OUT flags");
  in_read_clear_a: assert property ( // RULE3
    @(posedge sys_clk) disable iff (!rst_n)
    clk_en && rd_in && in_set == 4'h0
    |=> in_flags == 4'h0)
    else $error("IN flags not cleared by read");
  out_read_clear_a: assert property ( // RULE8
    @(posedge sys_clk) disable iff (!rst_n)
    clk_en && rd_out && out_set == 4'h0
    |=> out_flags == 4'h0)
    else $error("OUT flags not cleared by read");
  in_read_data_a: assert property ( // RULE6
    @(posedge sys_clk) disable iff (!rst_n)
    clk_en && rd_in
    |=> prdata == {28'h0, $past(in_flags)})
    else $error("IN read returned wrong flags");
  out_read_data_a: assert property ( // RULE8
    @(posedge sys_clk) disable iff (!rst_n)
    clk_en && rd_out
    |=> prdata == {28'h0, $past(out_flags)})
    else $error("OUT read returned wrong flags");
  in_bit_order_a: assert property ( // RULE6
    @(posedge sys_clk) disable iff (!rst_n)
    clk_en && control_ep_set
    |=> in_flags[0])
    else $error("Control endpoint flag not in bit 0");
  in_flag_set_a: assert property ( // RULE6
    @(posedge sys_clk) disable iff (!rst_n)
    clk_en
    |=> (in_flags & $past(in_set)) == $past(in_set))
    else $error("IN set pulse not held in its bit");
  out_flag_set_a: assert property ( // RULE7
    @(posedge sys_clk) disable iff (!rst_n)
    clk_en
    |=> (out_flags & $past(out_set)) == $past(out_set))
    else $error("OUT set pulse not held in its bit");
  out_bit0_a: assert property ( // RULE7
    @(posedge sys_clk) disable iff (!rst_n)
    1'b1
    |-> out_flags[0] == 1'b0)
    else $error("OUT bit 0 not zero");
  upper_zero_a: assert property ( // RULE9
    @(posedge sys_clk) disable iff (!rst_n)
    pready && !pwrite && (acc_sel == 3'h1 || acc_sel == 3'h2)
    |-> prdata[31:4] == 28'h0)
    else $error("Upper flag bits not zero");
  separate_store_a: assert property ( // RULE4
    @(posedge sys_clk) disable iff (!rst_n)
    clk_en && acc_wr && acc_sel == 3'h4 && first && in_set == 4'h0
    |=> s_r.evt_en == $past(pwdata[1:0]) && in_flags == $past(in_flags))
    else $error("Enable write mishandled");
  freeze_state_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    !clk_en
    |=> $stable(s_r) && $stable(in_flags) && $stable(out_flags))
    else $error("State moved while clock enable low");

  // APB answer
  ready_pulse_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    clk_en && pready
    |=> !pready)
    else $error("Ready stood longer than one cycle");
  bad_addr_err_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    clk_en && psel && penable && !pready && acc_sel == 3'h0
    |=> pready && pslverr)
    else $error("Unmapped access not answered with error");
  good_addr_ok_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    clk_en && psel && penable && !pready && acc_sel != 3'h0
    |=> pready && !pslverr)
    else $error("Mapped access not answered cleanly");
  err_with_ready_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    pslverr
    |-> pready)
    else $error("Error shown without ready");
  idle_no_ready_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    clk_en && !(psel && penable)
    |=> !pready && !pslverr)
    else $error("Ready raised with no access");
  zero_read_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    clk_en && acc_rd && first && (acc_sel == 3'h0 || acc_sel == 3'h5)
    |=> prdata == 32'h0)
    else $error("Unreadable location returned data");

  // Event status and irq
  status_read_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    clk_en && acc_rd && first && acc_sel == 3'h3
    |=> prdata == {30'h0, $past(s_r.evt_stat)})
    else $error("Status read returned wrong value");
  in_event_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    clk_en && |in_set
    |=> s_r.evt_stat[uef_pkg::EVT_IN_BIT])
    else $error("IN event not recorded");
  out_event_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    clk_en && |out_set
    |=> s_r.evt_stat[uef_pkg::EVT_OUT_BIT])
    else $error("OUT event not recorded");
  evt_clear_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    clk_en && acc_wr && first && acc_sel == 3'h5 && evt == 2'h0
    |=> (s_r.evt_stat & $past(pwdata[1:0])) == 2'h0)
    else $error("Status bits survived a clear write");
  irq_level_a: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    clk_en && evt_clr == 2'h0 && |(s_r.evt_stat & s_r.evt_en)
    |=> irq)
    else $error("Irq low with an enabled status bit set");

  rd_in_c: cover property (@(posedge sys_clk) rd_in && in_flags != 4'h0);
  rd_out_c: cover property (@(posedge sys_clk) rd_out && out_flags != 4'h0);
  irq_c: cover property (@(posedge sys_clk) usb_irq_req ##1 !usb_irq_req);
  race_c: cover property (@(posedge sys_clk) rd_in && in_set != 4'h0);
  err_c: cover property (@(posedge sys_clk) pslverr);
endmodule

//--- verif/uef_evt_model.sv
// Endpoint event source: turns a fire mask into set pulses one cycle later.
// Assumes the bench changes fire just after a rising edge.
`timescale 1ns/1ps
module uef_evt_model (
  // Clock and request
  input  wire logic       sys_clk,
  input  wire logic [6:0] fire,
  // Set pulses
  output logic      [6:0] set_pulse
);
  // Registered, so a pulse never shares an edge with the bench's write
  always_ff @(posedge sys_clk) begin
    set_pulse <= fire;
  end
endmodule

//--- verif/testbench.sv
// Self-checking bench for the endpoint pending-flag block.
// Assumes a one-wait-state APB answer and set pulses from uef_evt_model.
`timescale 1ns/1ps
module testbench;
  localparam logic [9:0] A_IN  = {uef_pkg::IDX_IN_FLAGS, 2'h0};
  localparam logic [9:0] A_OUT = {uef_pkg::IDX_OUT_FLAGS, 2'h0};
  localparam logic [9:0] A_ST  = {uef_pkg::IDX_IRQ_STATUS, 2'h0};
  localparam logic [9:0] A_EN  = {uef_pkg::IDX_IRQ_ENABLE, 2'h0};
  localparam logic [9:0] A_CLR = {uef_pkg::IDX_IRQ_CLEAR, 2'h0};
  localparam logic [9:0] A_EXT = {uef_pkg::IDX_EXT_ENABLE, 2'h0};
  logic        sys_clk = 1'b0;
  logic        rst_n   = 1'b0;
  logic        clk_en  = 1'b1;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [9:0]  paddr   = 10'h000;
  logic [31:0] pwdata  = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        usb_irq_req;
  logic        irq;
  logic [6:0]  fire    = 7'h00;
  logic [6:0]  sp;
  logic [31:0] rd;
  logic        er;
  logic [3:0]  exp_in  = 4'h0;
  logic [3:0]  exp_out = 4'h0;
  int          failures = 0;
  int          checks_done = 0;
  int          seed = 42880;

  always #12.5 sys_clk = ~sys_clk;

  uef_evt_model u_evt (.sys_clk(sys_clk), .fire(fire), .set_pulse(sp));

  uef_top DUT (
    .sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .control_ep_set(sp[0]), .tx_ep1_set(sp[1]),
    .tx_ep2_set(sp[2]), .tx_ep3_set(sp[3]), .rx_ep1_set(sp[4]),
    .rx_ep2_set(sp[5]), .rx_ep3_set(sp[6]),
    .usb_irq_req(usb_irq_req), .irq(irq)
  );

  task automatic summarize();
    if (failures == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, g);
    checks_done++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Holds the request until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [9:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      failures++;
      $display("CHECK FAILED pready expected 1 seen %b", pready);
      summarize();
    end else begin
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask

  task automatic rdchk(input string nm, input logic [9:0] a,
                       input logic [3:0] e);
    apb(1'b0, a, 32'h0);
    chk(nm, {28'h0, e}, rd);
    chk("rd_err", 32'h0, {31'h0, er});
  endtask

  // Mask bit 0 control, 1..3 IN endpoints, 4..6 OUT endpoints
  task automatic hit(input logic [6:0] mk);
    @(posedge sys_clk);
    fire <= mk;
    @(posedge sys_clk);
    fire <= 7'h00;
    exp_in = exp_in | mk[3:0];
    exp_out = exp_out | {mk[6:4], 1'b0};
    repeat (3) @(posedge sys_clk);
  endtask

  task automatic reqchk(input string nm, input logic e);
    chk(nm, {31'h0, e}, {31'h0, usb_irq_req});
  endtask

  initial begin
    repeat (12) @(posedge sys_clk);
    rst_n <= 1'b1;
    rdchk("in_reset", A_IN, 4'h0);
    rdchk("out_reset", A_OUT, 4'h0);
    hit(7'h01);
    reqchk("req_gated", 1'b0);
    apb(1'b1, A_EXT, 32'h1);
    repeat (2) @(posedge sys_clk);
    reqchk("req_on", 1'b1);
    rdchk("in_ep0", A_IN, exp_in);
    exp_in = 4'h0;
    rdchk("in_clear", A_IN, 4'h0);
    // Pulses while clk_en is low are dropped; the rest of the state holds
    @(posedge sys_clk);
    clk_en <= 1'b0;
    hit(7'h7f);
    clk_en <= 1'b1;
    exp_in = 4'h0;
    exp_out = 4'h0;
    reqchk("frz_req", 1'b0);
    rdchk("frz_in", A_IN, 4'h0);
    rdchk("frz_out", A_OUT, 4'h0);
    for (int i = 0; i < 7; i++) begin
      hit(7'h01 << i);
      reqchk("req_any", 1'b1);
      rdchk("in_bit", A_IN, exp_in);
      rdchk("out_bit", A_OUT, exp_out);
      exp_in = 4'h0;
      exp_out = 4'h0;
      repeat (2) @(posedge sys_clk);
      reqchk("req_drop", 1'b0);
    end
    // Writes of all ones and zeros must leave every flag alone
    hit(7'h55);
    apb(1'b1, A_IN, 32'hffff_ffff);
    apb(1'b1, A_OUT, 32'h0);
    rdchk("out_wr", A_OUT, exp_out);
    rdchk("in_wr", A_IN, exp_in);
    exp_in = 4'h0;
    exp_out = 4'h0;
    apb(1'b0, 10'h3fc, 32'h0);
    chk("bad_err", 32'h1, {31'h0, er});
    chk("irq_on", 32'h1, {31'h0, irq});
    apb(1'b1, A_EN, 32'h0);
    repeat (2) @(posedge sys_clk);
    chk("irq_mask", 32'h0, {31'h0, irq});
    apb(1'b1, A_CLR, 32'h3);
    apb(1'b0, A_ST, 32'h0);
    chk("irq_clr", 32'h0, rd);
    apb(1'b1, A_EN, 32'h3);
    hit(7'h10);
    apb(1'b0, A_ST, 32'h0);
    chk("irq_out_evt", 32'h2, rd);
    chk("irq_out", 32'h1, {31'h0, irq});
    for (int k = 0; k < 40; k++) begin
      hit(7'($random(seed)));
      reqchk("rnd_req", |{exp_in, exp_out});
      if (($random(seed) & 1) == 0) begin
        rdchk("rnd_in", A_IN, exp_in);
        exp_in = 4'h0;
      end else begin
        rdchk("rnd_out", A_OUT, exp_out);
        exp_out = 4'h0;
      end
    end
    summarize();
  end
endmodule
